// ===== rtl/cca_command_addressing.sv
// Functional notes
// RULE1: Global commands ignore channel enables.
// RULE2: Global access counts down like local, aborts.
// RULE3: Forty fourteen-bit words in five blocks.
// RULE4: Blocks one, two hold match and echo.
// RULE5: Block three holds scaling gain, tone.
// RULE6: Blocks four, five hold correction, gains.
// RULE7: Filter and gain words shared by channels.
// RULE8: Tone words stored per enabled channel.
// RULE9: Host enables a channel before tone access.
// RULE10: Word written as two bytes, low bits dropped.
// RULE11: Word read as sixteen bits, MSB first.
// RULE12: Coefficient address selects a whole block.
// RULE13: Eight words, top word down to bottom.
// RULE14: Chip select rise abandons current, later words.
// RULE15: Host selects channel via channel select write.
// RULE16: Local write 00001 fills two, then one.
// RULE17: Reads send identification byte, then descending data.
// RULE18: Global 00000 writes and reads register one.
// RULE19: Coefficient addresses 00000, 00010 hit blocks one, three.
// RULE20: Block bytes run high then low, descending.
// RULE21: Host may stop after fourth tone word.
// RULE22: Bit seven write, bits six-five type.
// RULE23: Low address bits give one to four registers.
// RULE24: Writes reach every enabled channel together.
// RULE25: Host enables one channel before reads.
// RULE26: Disallowed type discarded until chip select rises.
// RULE27: Chip select fall starts transfer with command.
`timescale 1ns/1ps
`default_nettype none

module cca_command_addressing (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_byte,
	input wire logic i_tx_req,
	output logic o_tx_valid,
	output logic [7:0] o_tx_byte,
	output logic o_reg_wr,
	output logic o_reg_rd,
	output logic o_reg_global,
	output logic [4:0] o_reg_addr,
	output logic [7:0] o_reg_wdata,
	input wire logic [7:0] i_reg_rdata,
	output logic [3:0] o_chan_enable,
	output logic [3:0] o_clock_select
);

	// ------------------------------------------------------------
	// Chip select synchroniser and edges
	// ------------------------------------------------------------
	logic cs_meta_q;
	logic cs_sync_q;
	logic cs_prev_q;
	logic cs_rise;
	logic cs_fall;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
			cs_prev_q <= 1'b1;
		end else begin
			cs_meta_q <= i_cs_n;
			cs_sync_q <= cs_meta_q;
			cs_prev_q <= cs_sync_q;
		end
	end

	assign cs_rise = cs_sync_q && !cs_prev_q;
	assign cs_fall = !cs_sync_q && cs_prev_q;

	// ------------------------------------------------------------
	// Command state
	// ------------------------------------------------------------
	cca_pkg::cca_state_t state_q, state_d;
	logic [1:0] type_q, type_d;
	logic [5:0] ptr_q, ptr_d;
	logic [4:0] cnt_q, cnt_d;
	logic lo_q, lo_d;
	logic id_q, id_d;
	logic [7:0] hi_q, hi_d;
	logic [7:0] chsel_q, chsel_d;
	logic tx_valid_q, tx_valid_d;
	logic [7:0] tx_byte_q, tx_byte_d;
	logic reg_wr_q, reg_wr_d;
	logic reg_global_q, reg_global_d;
	logic [4:0] reg_addr_q, reg_addr_d;
	logic [7:0] reg_wdata_q, reg_wdata_d;
	logic reg_rd;
	logic mem_we;
	logic [13:0] mem_wdata;
	logic [13:0] mem_rdata;
	logic [15:0] mem_rword;
	logic [1:0] cmd_type;
	logic cmd_write;

	assign cmd_type = i_rx_byte[cca_pkg::CCA_TYPE_MSB:cca_pkg::CCA_TYPE_LSB];
	assign cmd_write = i_rx_byte[cca_pkg::CCA_RW_BIT];
	assign mem_rword = {mem_rdata, 2'b00};
	assign mem_wdata = {hi_q, i_rx_byte[7:2]};

	always_comb begin
		state_d = state_q;
		type_d = type_q;
		ptr_d = ptr_q;
		cnt_d = cnt_q;
		lo_d = lo_q;
		id_d = id_q;
		hi_d = hi_q;
		chsel_d = chsel_q;
		tx_valid_d = 1'b0;
		tx_byte_d = tx_byte_q;
		reg_wr_d = 1'b0;
		reg_global_d = reg_global_q;
		reg_addr_d = reg_addr_q;
		reg_wdata_d = reg_wdata_q;
		reg_rd = 1'b0;
		mem_we = 1'b0;
		if (cs_rise) begin
			state_d = cca_pkg::CCA_ST_IDLE; // RULE14
		end else if (cs_fall) begin
			state_d = cca_pkg::CCA_ST_CMD; // RULE27
		end else begin
			unique case (state_q)
				cca_pkg::CCA_ST_CMD: begin
					if (i_rx_valid) begin
						type_d = cmd_type; // RULE22
						id_d = 1'b1;
						lo_d = 1'b0;
						state_d = cmd_write ? cca_pkg::CCA_ST_WRITE
							: cca_pkg::CCA_ST_READ;
						if (cmd_type == cca_pkg::CCA_TYPE_BAD) begin
							state_d = cca_pkg::CCA_ST_DISCARD; // RULE26
						end else if (cmd_type == cca_pkg::CCA_TYPE_COEF) begin
							if (i_rx_byte[4:0] > cca_pkg::CCA_LAST_BLOCK) begin
								state_d = cca_pkg::CCA_ST_DISCARD;
							end
							// Block index picks the top word of its block.
							ptr_d = {i_rx_byte[2:0], cca_pkg::CCA_TOP_IN_BLOCK}; // RULE12 RULE19
							cnt_d = cca_pkg::CCA_COEF_BYTES; // RULE13
						end else begin
							ptr_d = {1'b0, i_rx_byte[4:0]};
							cnt_d = {3'b000, i_rx_byte[1:0]} + 5'h01; // RULE23
							reg_global_d = (cmd_type == cca_pkg::CCA_TYPE_GLOBAL); // RULE1
							reg_addr_d = i_rx_byte[4:0]; // RULE18
						end
					end
				end
				cca_pkg::CCA_ST_WRITE: begin
					if (i_rx_valid) begin
						cnt_d = cnt_q - 5'h01;
						if (cnt_q == 5'h01) begin
							state_d = cca_pkg::CCA_ST_DISCARD;
						end
						if (type_q == cca_pkg::CCA_TYPE_COEF) begin
							if (!lo_q) begin
								hi_d = i_rx_byte; // RULE20
								lo_d = 1'b1;
							end else begin
								mem_we = 1'b1; // RULE10
								lo_d = 1'b0;
								ptr_d = ptr_q - 6'h01;
							end
						end else begin
							reg_wr_d = 1'b1; // RULE16
							reg_addr_d = ptr_q[4:0];
							reg_wdata_d = i_rx_byte;
							ptr_d = ptr_q - 6'h01; // RULE2
							if (reg_global_q
									&& ptr_q[4:0] == cca_pkg::CCA_CHSEL_ADDR) begin
								chsel_d = i_rx_byte; // RULE24
							end
						end
					end
				end
				cca_pkg::CCA_ST_READ: begin
					if (i_tx_req) begin
						tx_valid_d = 1'b1;
						tx_byte_d = cca_pkg::CCA_FILL_BYTE;
						if (id_q) begin
							tx_byte_d = cca_pkg::CCA_ID_BYTE; // RULE17
							id_d = 1'b0;
						end else if (cnt_q != 5'h00) begin
							cnt_d = cnt_q - 5'h01;
							if (type_q == cca_pkg::CCA_TYPE_COEF) begin
								tx_byte_d = lo_q ? mem_rword[7:0]
									: mem_rword[15:8]; // RULE11
								lo_d = !lo_q;
								if (lo_q) begin
									ptr_d = ptr_q - 6'h01;
								end
							end else begin
								reg_rd = 1'b1;
								tx_byte_d = i_reg_rdata;
								if (reg_global_q
										&& reg_addr_q == cca_pkg::CCA_CHSEL_ADDR) begin
									tx_byte_d = chsel_q;
								end
								ptr_d = ptr_q - 6'h01;
								reg_addr_d = ptr_d[4:0]; // RULE17
							end
						end
					end
				end
				cca_pkg::CCA_ST_IDLE, cca_pkg::CCA_ST_DISCARD: begin
					state_d = state_q;
				end
				default: begin
					state_d = cca_pkg::CCA_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= cca_pkg::CCA_ST_IDLE;
			type_q <= cca_pkg::CCA_TYPE_LOCAL;
			ptr_q <= 6'h00;
			cnt_q <= 5'h00;
			lo_q <= 1'b0;
			id_q <= 1'b0;
			hi_q <= 8'h00;
			chsel_q <= cca_pkg::CCA_CHSEL_RESET;
			tx_valid_q <= 1'b0;
			tx_byte_q <= 8'h00;
			reg_wr_q <= 1'b0;
			reg_global_q <= 1'b0;
			reg_addr_q <= 5'h00;
			reg_wdata_q <= 8'h00;
		end else begin
			state_q <= state_d;
			type_q <= type_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			lo_q <= lo_d;
			id_q <= id_d;
			hi_q <= hi_d;
			chsel_q <= chsel_d;
			tx_valid_q <= tx_valid_d;
			tx_byte_q <= tx_byte_d;
			reg_wr_q <= reg_wr_d;
			reg_global_q <= reg_global_d;
			reg_addr_q <= reg_addr_d;
			reg_wdata_q <= reg_wdata_d;
		end
	end

	assign o_tx_valid = tx_valid_q;
	assign o_tx_byte = tx_byte_q;
	assign o_reg_wr = reg_wr_q;
	assign o_reg_rd = reg_rd;
	assign o_reg_global = reg_global_q;
	assign o_reg_addr = reg_addr_q;
	assign o_reg_wdata = reg_wdata_q;
	assign o_chan_enable = chsel_q[cca_pkg::CCA_CE_MSB:cca_pkg::CCA_CE_LSB];
	assign o_clock_select = chsel_q[3:0];

	// ------------------------------------------------------------
	// Coefficient memory
	// ------------------------------------------------------------
	cca_coef_mem u_coef_mem (
		.i_clk_sys(i_clk_sys),
		.i_wr_en(mem_we), // RULE3
		.i_word(ptr_q), // RULE4 RULE5 RULE6
		.i_chan_mask(o_chan_enable), // RULE24
		.i_wdata(mem_wdata),
		.i_rd_chan(cca_pkg::cca_first_chan(o_chan_enable)),
		.o_rdata(mem_rdata)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_quiet;
		!cs_rise && !cs_fall;
	endsequence

	sequence s_cmd_byte;
		state_q == cca_pkg::CCA_ST_CMD && i_rx_valid ##0 s_quiet;
	endsequence

	property p_abort;
		cs_rise |=> state_q == cca_pkg::CCA_ST_IDLE && !o_reg_wr;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort on cs rise"); // RULE14

	property p_start;
		cs_fall |=> state_q == cca_pkg::CCA_ST_CMD;
	endproperty
	a_start: assert property (p_start) else $error("no command phase"); // RULE27

	property p_bad_type;
		s_cmd_byte ##0 cmd_type == cca_pkg::CCA_TYPE_BAD
			|=> state_q == cca_pkg::CCA_ST_DISCARD;
	endproperty
	a_bad_type: assert property (p_bad_type) else $error("bad type taken"); // RULE26

	property p_reg_count;
		s_cmd_byte ##0 cmd_type[1] == 1'b0
			|=> cnt_q == {3'b000, $past(i_rx_byte[1:0])} + 5'h01;
	endproperty
	a_reg_count: assert property (p_reg_count) else $error("bad count"); // RULE23

	property p_coef_top;
		s_cmd_byte ##0 cmd_type == cca_pkg::CCA_TYPE_COEF
			|=> ptr_q[2:0] == cca_pkg::CCA_TOP_IN_BLOCK
			&& cnt_q == cca_pkg::CCA_COEF_BYTES;
	endproperty
	a_coef_top: assert property (p_coef_top) else $error("bad block start"); // RULE13

	property p_id_first;
		state_q == cca_pkg::CCA_ST_READ && id_q && i_tx_req ##0 s_quiet
			|=> o_tx_valid && o_tx_byte == cca_pkg::CCA_ID_BYTE ##1 !id_q;
	endproperty
	a_id_first: assert property (p_id_first) else $error("id not first"); // RULE17

	property p_word_pair;
		mem_we |-> lo_q ##1 !lo_q && ptr_q == $past(ptr_q) - 6'h01;
	endproperty
	a_word_pair: assert property (p_word_pair) else $error("word pairing"); // RULE10

	property p_reg_desc;
		o_reg_wr && state_q == cca_pkg::CCA_ST_WRITE
			|-> ptr_q[4:0] == o_reg_addr - 5'h01;
	endproperty
	a_reg_desc: assert property (p_reg_desc) else $error("not descending"); // RULE2

	property p_chsel;
		state_q == cca_pkg::CCA_ST_WRITE && i_rx_valid && reg_global_q
			&& type_q == cca_pkg::CCA_TYPE_GLOBAL
			&& ptr_q[4:0] == cca_pkg::CCA_CHSEL_ADDR ##0 s_quiet
			|=> o_chan_enable == $past(i_rx_byte[7:4]);
	endproperty
	a_chsel: assert property (p_chsel) else $error("enable not taken"); // RULE24

endmodule : cca_command_addressing

`default_nettype wire

// ===== common/cca_pkg.sv
`default_nettype none

package cca_pkg;

	// ------------------------------------------------------------
	// Memory geometry
	// ------------------------------------------------------------
	localparam int unsigned CCA_WORDS = 40;
	localparam int unsigned CCA_BLOCK_WORDS = 8;
	localparam int unsigned CCA_WORD_W = 14;
	localparam int unsigned CCA_CHANNELS = 4;
	localparam int unsigned CCA_TONE_WORDS = 4;
	localparam logic [4:0] CCA_LAST_BLOCK = 5'h04;
	localparam logic [5:0] CCA_TONE_FIRST = 6'h14;
	localparam logic [5:0] CCA_TONE_LAST = 6'h17;
	localparam logic [2:0] CCA_TOP_IN_BLOCK = 3'h7;
	localparam logic [4:0] CCA_COEF_BYTES = 5'h10;

	// ------------------------------------------------------------
	// Command byte fields
	// ------------------------------------------------------------
	localparam int unsigned CCA_RW_BIT = 7;
	localparam int unsigned CCA_TYPE_MSB = 6;
	localparam int unsigned CCA_TYPE_LSB = 5;
	localparam int unsigned CCA_ADDR_MSB = 4;
	localparam int unsigned CCA_CNT_MSB = 1;
	localparam logic [1:0] CCA_TYPE_LOCAL = 2'h0;
	localparam logic [1:0] CCA_TYPE_GLOBAL = 2'h1;
	localparam logic [1:0] CCA_TYPE_BAD = 2'h2;
	localparam logic [1:0] CCA_TYPE_COEF = 2'h3;

	// ------------------------------------------------------------
	// Channel select register
	// ------------------------------------------------------------
	localparam logic [4:0] CCA_CHSEL_ADDR = 5'h05;
	localparam logic [7:0] CCA_CHSEL_RESET = 8'h02;
	localparam int unsigned CCA_CE_MSB = 7;
	localparam int unsigned CCA_CE_LSB = 4;

	// Identification byte sent ahead of read data; value is arbitrary.
	localparam logic [7:0] CCA_ID_BYTE = 8'h5A;
	localparam logic [7:0] CCA_FILL_BYTE = 8'h00;

	typedef enum logic [2:0] {
		CCA_ST_IDLE = 3'b000,
		CCA_ST_CMD = 3'b001,
		CCA_ST_WRITE = 3'b010,
		CCA_ST_READ = 3'b011,
		CCA_ST_DISCARD = 3'b100
	} cca_state_t;

	function automatic logic cca_is_tone(input logic [5:0] word);
		cca_is_tone = (word >= CCA_TONE_FIRST) && (word <= CCA_TONE_LAST);
	endfunction : cca_is_tone

	// Lowest enabled channel; reads are meant for one channel only.
	function automatic logic [1:0] cca_first_chan(input logic [3:0] mask);
		cca_first_chan = 2'h0;
		for (int c = 3; c >= 0; c--) begin
			if (mask[c]) begin
				cca_first_chan = 2'(c);
			end
		end
	endfunction : cca_first_chan

endpackage : cca_pkg

`default_nettype wire

// ===== rtl/cca_coef_mem.sv
`timescale 1ns/1ps
`default_nettype none

module cca_coef_mem (
	input wire logic i_clk_sys,
	input wire logic i_wr_en,
	input wire logic [5:0] i_word,
	input wire logic [3:0] i_chan_mask,
	input wire logic [13:0] i_wdata,
	input wire logic [1:0] i_rd_chan,
	output logic [13:0] o_rdata
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Contents survive reset, so the arrays carry no reset.
	logic [13:0] shared_q [0:cca_pkg::CCA_WORDS-1];
	logic [13:0] tone_q [0:cca_pkg::CCA_CHANNELS*cca_pkg::CCA_TONE_WORDS-1];
	logic tone_sel;

	assign tone_sel = cca_pkg::cca_is_tone(i_word);

	always_ff @(posedge i_clk_sys) begin
		if (i_wr_en && !tone_sel) begin
			shared_q[i_word] <= i_wdata; // RULE7
		end
		for (int c = 0; c < 4; c++) begin
			if (i_wr_en && tone_sel && i_chan_mask[c]) begin
				tone_q[{2'(c), i_word[1:0]}] <= i_wdata; // RULE8
			end
		end
	end

	always_comb begin
		if (tone_sel) begin
			o_rdata = tone_q[{i_rd_chan, i_word[1:0]}]; // RULE8
		end else begin
			o_rdata = shared_q[i_word];
		end
	end

endmodule : cca_coef_mem

`default_nettype wire

// ===== tb/cca_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cca_host_model (
	input wire logic i_clk_sys,
	output logic o_cs_n,
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte,
	output logic o_tx_req
);
	initial begin
		o_cs_n = 1'b1;
		o_rx_valid = 1'b0;
		o_rx_byte = 8'h00;
		o_tx_req = 1'b0;
	end

	// Every transfer opens with a fall of chip select.
	task automatic frame_open();
		@(posedge i_clk_sys);
		o_cs_n <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
	endtask : frame_open

	// Raising chip select may cut a transfer short.
	task automatic frame_close();
		@(posedge i_clk_sys);
		o_cs_n <= 1'b1;
		repeat (5) @(posedge i_clk_sys);
	endtask : frame_close

	// An idle data line shows the inverse of the last byte.
	task automatic put(input logic [7:0] b, input logic [1:0] gap);
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b1;
		o_rx_byte <= b;
		@(posedge i_clk_sys);
		o_rx_valid <= 1'b0;
		o_rx_byte <= ~b;
		repeat (gap) @(posedge i_clk_sys);
	endtask : put

	task automatic pull(input logic [1:0] gap);
		@(posedge i_clk_sys);
		o_tx_req <= 1'b1;
		@(posedge i_clk_sys);
		o_tx_req <= 1'b0;
		repeat (int'(gap) + 1) @(posedge i_clk_sys);
	endtask : pull

	// Enables are set before tone access and reads.
	task automatic chan_select(input logic [7:0] d);
		frame_open();
		put(8'hA5, 2'h0);
		put(d, 2'h0);
		frame_close();
	endtask : chan_select
endmodule : cca_host_model

`default_nettype wire

// ===== tb/cca_command_addressing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module cca_command_addressing_tb_top;
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic cs_n;
	logic rx_valid;
	logic tx_req;
	logic [7:0] rx_byte;
	logic tx_valid;
	logic [7:0] tx_byte;
	logic reg_wr;
	logic reg_rd;
	logic reg_global;
	logic [4:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [3:0] chan_enable;
	logic [3:0] clock_select;
	int bad_count = 0;
	int tests_run = 0;
	logic [15:0] seed = 16'h6C1C;
	logic [7:0] tx_q[$];
	logic [13:0] wr_q[$];
	logic [5:0] rd_q[$];
	logic [7:0] exp_tx;
	logic [13:0] exp_wr;
	logic [6:0] exp_rd;
	logic [7:0] chsel_val = cca_pkg::CCA_CHSEL_RESET;
	logic [7:0] bad_cmd [4] = '{8'hC0, 8'h40, 8'hE5, 8'h65};
	logic [13:0] mem [4][40];
	logic [3:0] en = 4'h0;

	always #5 i_clk_sys = ~i_clk_sys;

	function automatic logic [7:0] rfun(input logic g, input logic [4:0] a);
		rfun = {g, 2'b10, a} ^ 8'h3C;
	endfunction : rfun

	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		rnd = seed[7:0];
	endfunction : rnd

	assign reg_rdata = rfun(reg_global, reg_addr);

	cca_host_model u_cca_host_model (
		.i_clk_sys(i_clk_sys),
		.o_cs_n(cs_n),
		.o_rx_valid(rx_valid),
		.o_rx_byte(rx_byte),
		.o_tx_req(tx_req)
	);

	cca_command_addressing u_cca_command_addressing (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_cs_n(cs_n),
		.i_rx_valid(rx_valid),
		.i_rx_byte(rx_byte),
		.i_tx_req(tx_req),
		.o_tx_valid(tx_valid),
		.o_tx_byte(tx_byte),
		.o_reg_wr(reg_wr),
		.o_reg_rd(reg_rd),
		.o_reg_global(reg_global),
		.o_reg_addr(reg_addr),
		.o_reg_wdata(reg_wdata),
		.i_reg_rdata(reg_rdata),
		.o_chan_enable(chan_enable),
		.o_clock_select(clock_select)
	);

	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic give_verdict();
		$display("counts: %0d compared, %0d wrong", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	// An output with no note waiting is compared against its own inverse.
	always @(negedge i_clk_sys) begin
		if (tx_valid === 1'b1) begin
			exp_tx = (tx_q.size() != 0) ? tx_q.pop_front() : ~tx_byte;
			check(tx_byte, exp_tx);
		end
		if (reg_wr === 1'b1) begin
			exp_wr = (wr_q.size() != 0) ? wr_q.pop_front()
				: ~{reg_global, reg_addr, reg_wdata};
			check({reg_global, reg_addr, reg_wdata}, exp_wr);
		end
		// A register read strobe must sit in a request cycle.
		if (reg_rd === 1'b1) begin
			exp_rd = (rd_q.size() != 0) ? {1'b1, rd_q.pop_front()}
				: ~{tx_req, reg_global, reg_addr};
			check({tx_req, reg_global, reg_addr}, exp_rd);
		end
	end

	// ------------------------------------------------------------
	// Transfers
	// ------------------------------------------------------------
	task automatic settle(input string name);
		repeat (10) @(posedge i_clk_sys);
		check(16'(tx_q.size() + wr_q.size() + rd_q.size()), 16'h0000);
		$display("test %0s done", name);
	endtask : settle

	task automatic reg_write(input logic [7:0] cmd, input int n);
		int cnt;
		logic [7:0] b;
		cnt = int'(cmd[1:0]) + 1;
		u_cca_host_model.frame_open();
		u_cca_host_model.put(cmd, 2'(rnd()));
		for (int k = 0; k < n; k++) begin
			b = rnd();
			if (k < cnt) begin
				wr_q.push_back({cmd[6:5] == 2'h1, cmd[4:0] - 5'(k), b});
			end
			u_cca_host_model.put(b, 2'(rnd()));
		end
		u_cca_host_model.frame_close();
	endtask : reg_write

	task automatic reg_read(input logic [7:0] cmd);
		int cnt;
		logic g;
		logic [4:0] a;
		cnt = int'(cmd[1:0]) + 1;
		g = (cmd[6:5] == 2'h1);
		u_cca_host_model.frame_open();
		u_cca_host_model.put(cmd, 2'h0);
		tx_q.push_back(cca_pkg::CCA_ID_BYTE);
		for (int k = 0; k < cnt; k++) begin
			a = cmd[4:0] - 5'(k);
			rd_q.push_back({g, a});
			// The channel select register answers from inside the block.
			if (g && a == cca_pkg::CCA_CHSEL_ADDR) begin
				tx_q.push_back(chsel_val);
			end else begin
				tx_q.push_back(rfun(g, a));
			end
		end
		tx_q.push_back(8'h00);
		repeat (cnt + 2) u_cca_host_model.pull(2'(rnd()));
		u_cca_host_model.frame_close();
	endtask : reg_read

	task automatic chan(input logic [7:0] d);
		en = d[7:4];
		chsel_val = d;
		wr_q.push_back({1'b1, 5'h05, d});
		u_cca_host_model.chan_select(d);
		@(negedge i_clk_sys);
		check(chan_enable, d[7:4]);
		check(clock_select, d[3:0]);
	endtask : chan

	task automatic coef_write(input logic [2:0] blk, input int n);
		logic [7:0] hi;
		logic [7:0] b;
		int w;
		u_cca_host_model.frame_open();
		u_cca_host_model.put({5'b11100, blk}, 2'h0);
		for (int k = 0; k < n; k++) begin
			b = rnd();
			u_cca_host_model.put(b, 2'(rnd()));
			if (k % 2 == 0) begin
				hi = b;
			end else begin
				w = blk * 8 + 7 - k / 2;
				for (int c = 0; c < 4; c++) begin
					if (w < 20 || w > 23 || en[c]) begin
						mem[c][w] = {hi, b[7:2]};
					end
				end
			end
		end
		u_cca_host_model.frame_close();
	endtask : coef_write

	task automatic coef_read(input logic [2:0] blk);
		int ch;
		ch = en[0] ? 0 : (en[1] ? 1 : (en[2] ? 2 : 3));
		u_cca_host_model.frame_open();
		u_cca_host_model.put({5'b01100, blk}, 2'h0);
		tx_q.push_back(cca_pkg::CCA_ID_BYTE);
		for (int w = 7; w >= 0; w--) begin
			tx_q.push_back(mem[ch][blk * 8 + w][13:6]);
			tx_q.push_back({mem[ch][blk * 8 + w][5:0], 2'b00});
		end
		repeat (17) u_cca_host_model.pull(2'(rnd()));
		u_cca_host_model.frame_close();
	endtask : coef_read

	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		@(posedge i_clk_sys);
		reg_write(8'hA0, 2);
		reg_write(8'hA3, 2);
		reg_read(8'h20);
		reg_read(8'h25);
		settle("global");
		chan(8'h12);
		reg_write(8'h81, 3);
		reg_read(8'h03);
		settle("local");
		coef_write(3'h0, 16);
		coef_read(3'h0);
		coef_write(3'h4, 16);
		coef_read(3'h4);
		coef_write(3'h1, 16);
		coef_write(3'h1, 5);
		coef_read(3'h1);
		settle("shared blocks");
		chan(8'h32);
		coef_write(3'h2, 16);
		chan(8'h22);
		coef_write(3'h2, 9);
		chan(8'h12);
		coef_read(3'h2);
		chan(8'h22);
		coef_read(3'h2);
		settle("tone words");
		for (int i = 0; i < 4; i++) begin
			u_cca_host_model.frame_open();
			u_cca_host_model.put(bad_cmd[i], 2'h0);
			u_cca_host_model.put(rnd(), 2'h0);
			u_cca_host_model.pull(2'h0);
			u_cca_host_model.put(rnd(), 2'h0);
			u_cca_host_model.frame_close();
		end
		settle("refused commands");
		give_verdict();
	end

	initial begin
		repeat (30000) @(posedge i_clk_sys);
		bad_count++;
		give_verdict();
	end
endmodule : cca_command_addressing_tb_top

`default_nettype wire
